//--- common/dps_pkg.sv
// package for the processor reset and power status upper fields
package dps_pkg;
    // bit positions of the status word
    localparam int unsigned POS_PM_EXT = 16;
    localparam int unsigned POS_TR_EXT = 15;
    localparam int unsigned POS_DBG_EXT = 14;
    localparam int unsigned POS_TR_ERR = 13;
    localparam int unsigned POS_TR_DIS = 12;
    localparam int unsigned POS_RESTART = 11;
    localparam int unsigned STATUS_WIDTH = 32;
    // reset values of the sticky flags
    localparam logic RST_TR_ERR = 1'b0;
    localparam logic RST_RESTART = 1'b0;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // static feature straps of the core
    typedef struct packed {
        logic realm_feature_present;
        logic trace_buffer_feature_present;
        logic ext_trace_present;
        logic ext_perfmon_present;
        logic powerdown_domain_feature;
        logic double_lock_feature;
    } dps_feat_type;

    // live access-control state of the core
    typedef struct packed {
        logic core_power_on;
        logic double_lock_active;
        logic software_lock_active;
        logic reset_state;
        logic perfmon_access_disable_ext;
        logic trace_access_disable_ext;
        logic trace_access_disable;
        logic debug_access_disable_ext;
    } dps_ctrl_type;

    // read path states
    typedef enum logic [1:0] {
        DPS_IDLE,
        DPS_CLEAR
    } dps_rd_state_type;
endpackage : dps_pkg

//--- verilog/dps_sticky_flag.sv
// one sticky status flag with set-wins-over-clear behaviour
`timescale 1ns/1ns
`default_nettype none
module dps_sticky_flag
    import dps_pkg::*;
#(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic set_i,
    input wire logic clear_i,
    output logic flag_o
);
    logic flag_q;
    logic flag_d;

    // a set in the clearing cycle survives, so no event is lost
    assign flag_d = set_i ? 1'b1 : (clear_i ? 1'b0 : flag_q);

    // flag storage
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            flag_q <= RESET_VALUE;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;

    chk_set_wins: assert property (@(posedge clk_i) disable iff (reset_i)
        set_i |=> flag_q)
        else $error("sticky flag lost a set");
endmodule : dps_sticky_flag
`default_nettype wire

//--- verilog/dps_status_upper.sv
// upper fields of the processor reset and power status register
`timescale 1ns/1ns
`default_nettype none
module dps_status_upper
    import dps_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic warm_reset_i,
    input wire dps_feat_type feat_i,
    input wire dps_ctrl_type ctrl_i,
    input wire logic trace_access_error_i,
    input wire logic debug_state_i,
    input wire logic status_read_i,
    input wire logic status_write_i,
    input wire logic [31:0] status_wdata_i,
    output logic [31:0] status_rdata_o,
    output logic status_rvalid_o,
    output logic read_strobe_o
);
    ////////////////////////////////////////////////////////////////////////
    // feature gating
    ////////////////////////////////////////////////////////////////////////
    wire logic has_pm_ext;
    wire logic has_tr_ext;
    wire logic has_dbg_ext;
    wire logic has_trace;
    assign has_pm_ext = feat_i.realm_feature_present & feat_i.ext_perfmon_present;
    assign has_tr_ext = feat_i.realm_feature_present & feat_i.ext_trace_present
                      & feat_i.trace_buffer_feature_present;
    assign has_dbg_ext = feat_i.realm_feature_present;
    assign has_trace = feat_i.ext_trace_present & feat_i.trace_buffer_feature_present;

    // field is locked out: unknown value, which this design returns as zero
    wire logic locked_out;
    assign locked_out = ctrl_i.double_lock_active | ctrl_i.reset_state
                      | (~feat_i.powerdown_domain_feature & ~ctrl_i.core_power_on);

    // clearing allowed only when powered and not double locked; under double lock
    // we choose to hold, which is one of the permitted outcomes
    wire logic clear_ok;
    assign clear_ok = ctrl_i.core_power_on & ~ctrl_i.double_lock_active;

    ////////////////////////////////////////////////////////////////////////
    // debug state exit detection
    ////////////////////////////////////////////////////////////////////////
    logic dbg_state_q;
    wire logic dbg_state_d;
    wire logic dbg_exit;
    // a warm reset forces the core out of debug state, so it counts as an exit
    assign dbg_state_d = debug_state_i & ~warm_reset_i;
    assign dbg_exit = dbg_state_q & ~dbg_state_d;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            dbg_state_q <= 1'b0;
        end else begin
            dbg_state_q <= dbg_state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read sequencing
    ////////////////////////////////////////////////////////////////////////
    dps_rd_state_type rd_state_q;
    dps_rd_state_type rd_state_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rvalid_q;
    logic strobe_q;
    wire logic strobe_d;
    wire logic clr_tr_err;
    wire logic clr_restart;
    logic tr_err;
    logic restart;

    // strobe rises on the same edge as the capture, so the word already holds the flags
    assign strobe_d = (rd_state_q == DPS_IDLE) & status_read_i;

    always_comb begin
        rd_state_d = rd_state_q;
        case (rd_state_q)
            DPS_IDLE: begin
                if (status_read_i) begin
                    rd_state_d = DPS_CLEAR;
                end
            end
            DPS_CLEAR: begin
                rd_state_d = DPS_IDLE;
            end
            default: begin
                rd_state_d = DPS_IDLE;
            end
        endcase
    end

    assign clr_tr_err = strobe_q & clear_ok & ~locked_out;
    assign clr_restart = strobe_q & clear_ok & ~locked_out & ~ctrl_i.software_lock_active;

    ////////////////////////////////////////////////////////////////////////
    // sticky flags
    ////////////////////////////////////////////////////////////////////////
    // writes never reach the flags; status_write_i is deliberately unused for state
    dps_sticky_flag #(
        .RESET_VALUE(RST_TR_ERR)
    ) u_tr_err (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .set_i(trace_access_error_i & has_trace),
        .clear_i(clr_tr_err),
        .flag_o(tr_err)
    );

    // warm reset leaves it unknown; defined here as cleared for determinism, or set when the reset ends debug state
    dps_sticky_flag #(
        .RESET_VALUE(RST_RESTART)
    ) u_restart (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .set_i(dbg_exit),
        .clear_i(clr_restart | (warm_reset_i & ~dbg_exit)),
        .flag_o(restart)
    );

    ////////////////////////////////////////////////////////////////////////
    // read data assembly
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        rdata_d = ZERO_WORD;
        if (!locked_out) begin
            rdata_d[POS_PM_EXT] = has_pm_ext & ctrl_i.perfmon_access_disable_ext;
            rdata_d[POS_TR_EXT] = has_tr_ext & ctrl_i.trace_access_disable_ext;
            rdata_d[POS_DBG_EXT] = has_dbg_ext & ctrl_i.debug_access_disable_ext;
            rdata_d[POS_TR_ERR] = has_trace & tr_err;
            rdata_d[POS_TR_DIS] = has_trace & ctrl_i.trace_access_disable;
            rdata_d[POS_RESTART] = restart;
        end
    end

    // capture the word on the read, flags clear one cycle later
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_state_q <= DPS_IDLE;
            rdata_q <= ZERO_WORD;
            rvalid_q <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            rd_state_q <= rd_state_d;
            rdata_q <= status_read_i ? rdata_d : rdata_q;
            rvalid_q <= status_read_i;
            strobe_q <= strobe_d;
        end
    end

    assign status_rdata_o = rdata_q;
    assign status_rvalid_o = rvalid_q;
    assign read_strobe_o = strobe_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////////
    chk_upper_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        status_rvalid_o |-> status_rdata_o[31:17] == 15'h0000)
        else $error("reserved bits nonzero");
    chk_strobe_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
        read_strobe_o |=> !read_strobe_o)
        else $error("read strobe longer than one cycle");
    chk_strobe_after: assert property (@(posedge clk_i) disable iff (reset_i)
        read_strobe_o |-> $past(status_read_i))
        else $error("strobe without read");
    chk_err_sets: assert property (@(posedge clk_i) disable iff (reset_i)
        (trace_access_error_i && has_trace) |=> tr_err)
        else $error("trace error not recorded");
    chk_err_clears: assert property (@(posedge clk_i) disable iff (reset_i)
        (clr_tr_err && !(trace_access_error_i && has_trace)) |=> !tr_err)
        else $error("trace error not cleared by read");
    chk_restart_sets: assert property (@(posedge clk_i) disable iff (reset_i)
        (dbg_state_q && !debug_state_i) |=> restart)
        else $error("restart not recorded");
    chk_swlock_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        (restart && ctrl_i.software_lock_active && !warm_reset_i) |=> restart)
        else $error("restart cleared under software lock");
    chk_dlock_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        (tr_err && ctrl_i.double_lock_active) |=> tr_err)
        else $error("trace error cleared under double lock");
    chk_warm_exit: assert property (@(posedge clk_i) disable iff (reset_i)
        (dbg_state_q && warm_reset_i) |=> restart)
        else $error("reset in debug state not an exit");
    chk_locked_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        (status_read_i && locked_out) |=> status_rdata_o == ZERO_WORD)
        else $error("locked read returned data");
    chk_ext_gate: assert property (@(posedge clk_i) disable iff (reset_i)
        (status_read_i && !feat_i.realm_feature_present) |=> status_rdata_o[16:14] == 3'h0)
        else $error("extended bits set without realm");

    // answer timing and field contents
    // valid follows every read by exactly one cycle
    chk_rvalid_follows: assert property (@(posedge clk_i) disable iff (reset_i)
        status_read_i |=> status_rvalid_o)
        else $error("read not answered");
    // valid never appears without a read before it
    chk_rvalid_cause: assert property (@(posedge clk_i) disable iff (reset_i)
        status_rvalid_o |-> $past(status_read_i))
        else $error("answer without read");
    // the debugger may sample the word late, so it must not drift between reads
    chk_rdata_held: assert property (@(posedge clk_i) disable iff (reset_i)
        !status_read_i |=> $stable(status_rdata_o))
        else $error("read word changed without a read");
    // bits below the restart flag are outside this block and read zero
    chk_reserved_low: assert property (@(posedge clk_i) disable iff (reset_i)
        status_rvalid_o |-> status_rdata_o[10:0] == 11'h000)
        else $error("low bits nonzero");
    // perfmon extended bit needs realm and external monitor access
    chk_pm_gate: assert property (@(posedge clk_i) disable iff (reset_i)
        (status_read_i && !has_pm_ext) |=> !status_rdata_o[POS_PM_EXT])
        else $error("perfmon extended bit without feature");
    // trace extended bit needs realm, external trace and the trace buffer
    chk_tr_ext_gate: assert property (@(posedge clk_i) disable iff (reset_i)
        (status_read_i && !has_tr_ext) |=> !status_rdata_o[POS_TR_EXT])
        else $error("trace extended bit without feature");
    // without trace access both trace fields read zero
    chk_trace_gate: assert property (@(posedge clk_i) disable iff (reset_i)
        (status_read_i && !has_trace) |=> !status_rdata_o[POS_TR_ERR] && !status_rdata_o[POS_TR_DIS])
        else $error("trace fields without trace access");
    // debug extended bit reports the live access-disable state at the read
    chk_dbg_ext_field: assert property (@(posedge clk_i) disable iff (reset_i)
        (status_read_i && !locked_out && has_dbg_ext)
        |=> status_rdata_o[POS_DBG_EXT] == $past(ctrl_i.debug_access_disable_ext))
        else $error("debug extended bit wrong");
    // trace disable bit reports the live access-disable state at the read
    chk_dis_field: assert property (@(posedge clk_i) disable iff (reset_i)
        (status_read_i && !locked_out && has_trace)
        |=> status_rdata_o[POS_TR_DIS] == $past(ctrl_i.trace_access_disable))
        else $error("trace disable bit wrong");
    // the word carries the error flag as it stood at the read, before clearing
    chk_err_field: assert property (@(posedge clk_i) disable iff (reset_i)
        (status_read_i && !locked_out) |=> status_rdata_o[POS_TR_ERR] == (has_trace && $past(tr_err)))
        else $error("trace error bit wrong");
    // the word carries the restart flag as it stood at the read
    chk_restart_field: assert property (@(posedge clk_i) disable iff (reset_i)
        (status_read_i && !locked_out) |=> status_rdata_o[POS_RESTART] == $past(restart))
        else $error("restart bit wrong");

    // clearing paths and what must hold the flags
    // the strobe clears the restart flag when clearing is allowed and no software lock holds, unless a new exit arrives
    chk_restart_clears: assert property (@(posedge clk_i) disable iff (reset_i)
        (clr_restart && !dbg_exit) |=> !restart)
        else $error("restart not cleared by read");
    // a warm reset outside debug state leaves the restart flag defined as zero
    chk_warm_clear: assert property (@(posedge clk_i) disable iff (reset_i)
        (warm_reset_i && !dbg_exit) |=> !restart)
        else $error("restart kept over warm reset");
    // a write must not act as a clear of the error flag
    chk_write_err_kept: assert property (@(posedge clk_i) disable iff (reset_i)
        (status_write_i && tr_err && !clr_tr_err) |=> tr_err)
        else $error("write cleared trace error");
    // writing a one to the restart bit must not clear it either
    chk_write_restart_kept: assert property (@(posedge clk_i) disable iff (reset_i)
        (status_write_i && status_wdata_i[POS_RESTART] && restart && !clr_restart && !warm_reset_i) |=> restart)
        else $error("write cleared restart");
    // a locked-out field clears nothing, whatever is read
    chk_locked_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        (locked_out && tr_err) |=> tr_err)
        else $error("trace error cleared while locked out");
    // reads while the core is unpowered leave the restart flag alone
    chk_unpowered_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        (!ctrl_i.core_power_on && restart && !warm_reset_i) |=> restart)
        else $error("restart cleared while unpowered");
    // a read taken from idle always launches the clear strobe
    chk_strobe_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        (status_read_i && !status_rvalid_o) |=> read_strobe_o)
        else $error("read from idle gave no strobe");

    // main scenarios
    cov_read_clear: cover property (@(posedge clk_i) disable iff (reset_i)
        tr_err ##1 status_read_i ##2 !tr_err);
    cov_restart: cover property (@(posedge clk_i) disable iff (reset_i)
        dbg_exit ##[1:4] status_read_i);
    cov_set_on_clear: cover property (@(posedge clk_i) disable iff (reset_i)
        clr_tr_err && trace_access_error_i);
    cov_warm_in_debug: cover property (@(posedge clk_i) disable iff (reset_i)
        dbg_state_q && warm_reset_i);
    cov_locked_read: cover property (@(posedge clk_i) disable iff (reset_i)
        status_read_i && locked_out);
endmodule : dps_status_upper
`default_nettype wire

//--- verif/dps_debugger_model.sv
// debugger model that reads and writes the status word over the debug port
`timescale 1ns/1ns
`default_nettype none
module dps_debugger_model (
    input wire logic clk_i,
    input wire logic [31:0] status_rdata_i,
    input wire logic status_rvalid_i,
    input wire logic read_strobe_i,
    output logic status_read_o,
    output logic status_write_o,
    output logic [31:0] status_wdata_o
);
    logic [31:0] got_w[$];
    logic [1:0] got_f[$];
    initial begin
        status_read_o = 1'b0;
        status_write_o = 1'b0;
        status_wdata_o = 32'h0000_0000;
    end
    ////////////////////////////////////////////////////////////////////////
    // n reads back to back; answers are taken in their own answer cycle
    task automatic read_burst(input int n);
        @(posedge clk_i);
        status_read_o <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            status_read_o <= (i < n - 1);
            #1;
            got_w.push_back(status_rdata_i); // restart flag is judged with the model restart flag m_rst by the bench
            got_f.push_back({status_rvalid_i, read_strobe_i});
        end
    endtask : read_burst
    // write data is inverted once released so a stale value is never seen
    task automatic write_word(input logic [31:0] w);
        @(posedge clk_i);
        status_write_o <= 1'b1;
        status_wdata_o <= w;
        @(posedge clk_i);
        status_write_o <= 1'b0;
        status_wdata_o <= ~w;
    endtask : write_word
endmodule : dps_debugger_model
`default_nettype wire

//--- verif/debug_proc_status_upper_fields_tb.sv
// self-checking bench for the status word upper fields
`timescale 1ns/1ns
`default_nettype none
module debug_proc_status_upper_fields_tb
    import dps_pkg::*;
;
    logic clk_i, reset_i, warm, terr, dbg, rd, wr, rvalid, strobe, lo, tr_ok;
    logic [31:0] wd, rdata, rnd;
    dps_feat_type feat;
    dps_ctrl_type ctrl;
    int seed, fail_count, cmp_count, m_err, m_rst;
    dps_status_upper dps_status_upper_inst (.clk_i(clk_i), .reset_i(reset_i), .warm_reset_i(warm),
        .feat_i(feat), .ctrl_i(ctrl), .trace_access_error_i(terr), .debug_state_i(dbg),
        .status_read_i(rd), .status_write_i(wr), .status_wdata_i(wd), .status_rdata_o(rdata),
        .status_rvalid_o(rvalid), .read_strobe_o(strobe));
    dps_debugger_model dps_debugger_model_inst (.clk_i(clk_i), .status_rdata_i(rdata),
        .status_rvalid_i(rvalid), .read_strobe_i(strobe), .status_read_o(rd),
        .status_write_o(wr), .status_wdata_o(wd));
    // locked-out reads give zero and clear nothing
    assign lo = ctrl.double_lock_active | ctrl.reset_state | (!feat.powerdown_domain_feature & !ctrl.core_power_on);
    assign tr_ok = feat.ext_trace_present & feat.trace_buffer_feature_present;
    ////////////////////////////////////////////////////////////////////////
    // reference word from the straps, the access state and the model flags
    function automatic logic [31:0] exp_word();
        logic [31:0] w;
        w = ZERO_WORD;
        if (!lo) begin
            w[POS_PM_EXT] = feat.realm_feature_present & feat.ext_perfmon_present & ctrl.perfmon_access_disable_ext;
            w[POS_TR_EXT] = feat.realm_feature_present & tr_ok & ctrl.trace_access_disable_ext;
            w[POS_DBG_EXT] = feat.realm_feature_present & ctrl.debug_access_disable_ext;
            w[POS_TR_ERR] = tr_ok & (m_err != 0);
            w[POS_TR_DIS] = tr_ok & ctrl.trace_access_disable;
            w[POS_RESTART] = (m_rst != 0);
        end
        return w;
    endfunction : exp_word
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // reads, compares every answer, then applies the clear-on-read to the model
    task automatic do_read(input int n);
        logic [31:0] e;
        #1;
        e = exp_word();
        dps_debugger_model_inst.read_burst(n);
        for (int i = 0; i < n; i++) begin
            check(dps_debugger_model_inst.got_w.pop_front(), e);
            check({30'h0, dps_debugger_model_inst.got_f.pop_front()}, {30'h0, 1'b1, i == 0});
        end
        if (!lo && ctrl.core_power_on) begin
            m_err = 0;
            if (!ctrl.software_lock_active) begin
                m_rst = 0;
            end
        end
    endtask : do_read
    // raise a trace error and/or a debug exit; settle before any read
    task automatic flags(input logic e, input logic r);
        @(posedge clk_i);
        terr <= e;
        dbg <= r;
        repeat (2) @(posedge clk_i);
        terr <= 1'b0;
        dbg <= 1'b0;
        repeat (2) @(posedge clk_i);
        m_err = e ? 1 : m_err;
        m_rst = r ? 1 : m_rst;
    endtask : flags
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // watchdog sized well above the roughly 80 cycles the run needs
    initial begin
        #200000;
        fail_count++;
        conclude();
    end
    initial begin
        seed = 5771;
        {reset_i, warm, terr, dbg, m_err, m_rst, fail_count, cmp_count} = {4'b1000, 128'h0};
        feat = '1;
        ctrl = 8'h80;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        do_read(1);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_i);
            rnd = $random(seed);
            feat <= rnd[5:0];
            ctrl <= (k < 4) ? {4'h8, rnd[9:6]} : rnd[13:6]; // later passes also try the lockouts
            do_read(1);
        end
        feat <= '1;
        ctrl[7:4] <= 4'h8;
        flags(1'b1, 1'b1);
        do_read(2);
        do_read(1);
        ctrl.software_lock_active <= 1'b1;
        flags(1'b1, 1'b1);
        do_read(1);
        // the clear is judged at the strobe, one edge after the read
        @(posedge clk_i);
        ctrl.software_lock_active <= 1'b0;
        do_read(1);
        flags(1'b1, 1'b1);
        ctrl.double_lock_active <= 1'b1;
        do_read(1);
        @(posedge clk_i);
        ctrl.double_lock_active <= 1'b0;
        dps_debugger_model_inst.write_word(32'hffff_ffff);
        do_read(1);
        // warm reset inside debug state counts as an exit
        @(posedge clk_i);
        dbg <= 1'b1;
        @(posedge clk_i);
        warm <= 1'b1;
        @(posedge clk_i);
        dbg <= 1'b0;
        warm <= 1'b0;
        m_rst = 1;
        do_read(1);
        flags(1'b0, 1'b1);
        @(posedge clk_i);
        warm <= 1'b1;
        @(posedge clk_i);
        warm <= 1'b0;
        m_rst = 0;
        do_read(1);
        flags(1'b1, 1'b1);
        reset_i <= 1'b1;
        @(posedge clk_i);
        reset_i <= 1'b0;
        {m_err, m_rst} = 64'h0;
        do_read(1);
        conclude();
    end
endmodule : debug_proc_status_upper_fields_tb
`default_nettype wire
